// ### rtl/rst_seq_cfg.svh
// Purpose: timing and encoding constants for the reset pin sequencer
// Assumes: core clock is the pll_output_clock, 20 MHz
// Notes: counts are in pll_output_clock cycles
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH
`define RST_DRIVE_CYCLES 512
`define RST_SEQ_CYCLES 768
`define RST_CNT_W 10
`define RST_PIN_ACTIVE 1'h0
`define RST_PIN_IDLE 1'h1
`endif

// ### rtl/rst_seq_pkg.sv
// Purpose: types for the reset pin sequencer
// Assumes: nothing
// Notes: states of the sequence engine
package rst_seq_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DRIVE,
      ST_WAIT,
      ST_EXT_HOLD
   } rst_seq_state_t;
endpackage

// ### rtl/rst_pin_sync.sv
// Purpose: two-flop synchroniser for the reset pin input level
// Assumes: pin level may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`include "rst_seq_cfg.svh"
module rst_pin_sync (
   input wire logic i_core_clk, // core clock
   input wire logic i_srst,     // sync reset, active high
   input wire logic i_pin,      // raw pin level
   output logic o_pin_sync      // synchronised level
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = i_pin;
      sync_nxt = meta_r;
   end

   // reset to idle high so a reset does not look like an external hold
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         meta_r <= `RST_PIN_IDLE;
         sync_r <= `RST_PIN_IDLE;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_pin_sync = sync_r;
endmodule

// ### rtl/reset_pin_sequencer.sv
// Purpose: drives the bidirectional active-low reset pin and internal reset
// Assumes: i_core_clk is the pll_output_clock; pin resolved outside
// Notes: pull-up requested by a static output flag to the pad
// Summary of operation
// (RULE1) reset pin active low, bidirectional, external low resets
// (RULE2) any reset source drives pin low 512 cycles
// (RULE3) after 512 cycles release the pin
// (RULE4) internal reset held for full 768-cycle sequence
// (RULE5) pin held low externally extends internal reset
// (RULE6) internal pull-up keeps pin high when undriven
// (RULE7) sample synchronised pin after release, detect external hold
`timescale 1ns/10ps
`include "rst_seq_cfg.svh"
module reset_pin_sequencer
   import rst_seq_pkg::*;
#(
   parameter int DRIVE_CYCLES = `RST_DRIVE_CYCLES,
   parameter int SEQ_CYCLES = `RST_SEQ_CYCLES
) (
   input wire logic i_core_clk,  // pll_output_clock, 20 MHz
   input wire logic i_srst,      // sync reset, active high
   input wire logic i_rst_src,   // internal reset source, level or pulse
   input wire logic i_rst_pin,   // reset pin level in
   output logic o_rst_pin,       // reset pin level out
   output logic o_rst_pin_oe,    // reset pin output enable
   output logic o_rst_pin_pu,    // pad pull-up enable
   output logic o_int_rst,       // internal reset, active high
   output logic o_ext_hold       // external hold seen at sequence end
);
   localparam int CW = `RST_CNT_W;

   // the counter must reach the full sequence length without wrapping
   if (DRIVE_CYCLES < 1 || SEQ_CYCLES <= DRIVE_CYCLES
         || SEQ_CYCLES >= (1 << CW)) begin : g_bad_counts
      $error("reset_pin_sequencer: bad cycle counts");
   end

   // ==========================================================
   // pin synchroniser
   logic pin_sync;

   rst_pin_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_pin(i_rst_pin),
      .o_pin_sync(pin_sync)
   );

   // ==========================================================
   // sequence engine
   rst_seq_state_t state_r;
   rst_seq_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic oe_r;
   logic oe_nxt;
   logic irst_r;
   logic irst_nxt;
   logic hold_r;
   logic hold_nxt;
   logic ext_low;

   function automatic logic [CW-1:0] to_cnt(input int v);
      to_cnt = CW'(v);
   endfunction

   // a low pin while we are not driving it is an outside reset
   assign ext_low = (pin_sync == `RST_PIN_ACTIVE); // RULE1

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      oe_nxt = oe_r;
      irst_nxt = irst_r;
      hold_nxt = hold_r;
      unique case (state_r)
         ST_IDLE: begin
            if (i_rst_src || ext_low) begin
               state_nxt = ST_DRIVE; // RULE2
               cnt_nxt = to_cnt(1);
               oe_nxt = 1'b1;
               irst_nxt = 1'b1;
               hold_nxt = 1'b0;
            end
         end
         ST_DRIVE: begin
            cnt_nxt = cnt_r + to_cnt(1);
            if (cnt_r == to_cnt(DRIVE_CYCLES)) begin
               state_nxt = ST_WAIT; // RULE3
               oe_nxt = 1'b0;
            end
         end
         ST_WAIT: begin
            cnt_nxt = cnt_r + to_cnt(1);
            if (cnt_r == to_cnt(SEQ_CYCLES)) begin
               if (ext_low) begin
                  state_nxt = ST_EXT_HOLD; // RULE7
                  hold_nxt = 1'b1;
               end else begin
                  state_nxt = ST_IDLE; // RULE4
                  irst_nxt = 1'b0;
               end
            end
         end
         ST_EXT_HOLD: begin
            if (!ext_low) begin
               state_nxt = ST_IDLE; // RULE5
               irst_nxt = 1'b0;
               hold_nxt = 1'b0;
            end
         end
      endcase
   end

   // reset starts a full sequence: internal reset asserted, pin driven
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state_r <= ST_DRIVE;
         cnt_r <= to_cnt(1);
         oe_r <= 1'b1;
         irst_r <= 1'b1;
         hold_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         oe_r <= oe_nxt;
         irst_r <= irst_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign o_rst_pin = `RST_PIN_ACTIVE; // RULE1
   assign o_rst_pin_oe = oe_r;
   assign o_rst_pin_pu = 1'b1; // RULE6
   assign o_int_rst = irst_r;
   assign o_ext_hold = hold_r;

   // ==========================================================
   // assertions
   // helper counters measure how long the pin drive and the internal reset last
   logic [CW-1:0] oe_len_r;
   logic [CW-1:0] oe_len_nxt;
   logic [CW-1:0] irst_len_r;
   logic [CW-1:0] irst_len_nxt;

   always_comb begin
      oe_len_nxt = '0;
      irst_len_nxt = '0;
      if (o_rst_pin_oe) begin
         oe_len_nxt = oe_len_r + to_cnt(1);
      end
      // saturate: an outside hold may outlast the counter
      if (o_int_rst) begin
         irst_len_nxt = (irst_len_r == '1) ? irst_len_r : irst_len_r + to_cnt(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         oe_len_r <= '0;
         irst_len_r <= '0;
      end else begin
         oe_len_r <= oe_len_nxt;
         irst_len_r <= irst_len_nxt;
      end
   end

   sequence s_drive_start;
      $rose(o_rst_pin_oe);
   endsequence

   sequence s_drive_end;
      $fell(o_rst_pin_oe);
   endsequence

   sequence s_idle_request;
      state_r == ST_IDLE && (i_rst_src || ext_low);
   endsequence

   sequence s_hold_over;
      state_r == ST_EXT_HOLD && !ext_low;
   endsequence

   // the counter already holds the full drive length at the edge the drop is seen
   a_drive_len: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE2
      s_drive_end |-> oe_len_r == to_cnt(DRIVE_CYCLES))
      else $error("reset pin drive length wrong");

   a_req_start: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE2
      s_idle_request |=> s_drive_start)
      else $error("reset request did not start the drive");

   a_release_rest: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE3
      s_drive_end |-> !o_rst_pin_oe [*8])
      else $error("reset pin driven again after release");

   a_irst_len: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE4
      $fell(o_int_rst) && !$past(o_ext_hold) |-> irst_len_r == to_cnt(SEQ_CYCLES))
      else $error("internal reset length wrong");

   a_hold_release: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE5
      s_hold_over |=> !o_int_rst && !o_ext_hold)
      else $error("internal reset kept after pin released");

   a_hold_entry: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE7
      $rose(o_ext_hold) |-> o_int_rst && irst_len_r == to_cnt(SEQ_CYCLES))
      else $error("external hold not decided at sequence end");

   a_drive_cap: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE3
      oe_len_r <= to_cnt(DRIVE_CYCLES))
      else $error("reset pin driven too long");

   a_irst_cover: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE4
      s_drive_end |-> o_int_rst [*8])
      else $error("internal reset dropped early");

   a_irst_end: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE4
      $fell(o_int_rst) |-> $past(state_r) != ST_DRIVE && !o_rst_pin_oe)
      else $error("internal reset released during drive");

   a_ext_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE5
      (state_r == ST_EXT_HOLD && ext_low) |=> o_int_rst)
      else $error("internal reset dropped while pin held low");

   a_hold_flag: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE7
      o_ext_hold |-> o_int_rst && !o_rst_pin_oe)
      else $error("external hold flag inconsistent");

   a_pull_up: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE6
      o_rst_pin_pu)
      else $error("pull-up disabled");

   a_pin_low: assert property (@(posedge i_core_clk) disable iff (i_srst) // RULE1
      s_drive_start |-> o_rst_pin == `RST_PIN_ACTIVE && o_int_rst)
      else $error("pin drive not low");
endmodule

// ### dv/ext_rst_board.sv
// Purpose: board-side reset circuitry sharing the reset pin
// Assumes: device output only ever pulls the pin low
// Notes: i_ext_low is commanded by the bench
`timescale 1ns/10ps
module ext_rst_board (
   input wire logic i_oe,      // device drives pin
   input wire logic i_drv,     // device drive level
   input wire logic i_ext_low, // board holds pin low
   output logic o_pin          // resolved pin level
);
   // ==========
   // pin resolution
   // released pin goes to the pull-up level, never to the last value
   assign o_pin = ((i_oe && !i_drv) || i_ext_low) ? 1'h0 : 1'h1;
endmodule

// ### dv/test_reset_pin_sequencer.sv
// Purpose: self-checking bench for the reset pin sequencer
// Assumes: short counts of 8 and 16 cycles stand in for 512 and 768
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
module test_reset_pin_sequencer;
   localparam int D = 8;
   localparam int S = 16;
   logic i_core_clk = 1'h0, i_srst = 1'h1, i_rst_src = 1'h0, ext_low = 1'h0;
   logic pin, oe, drv, pu, int_rst, xhold, xh;
   int bad_count = 0, n_checks = 0, seed = 32'h0A00D501;
   int n_oe, n_int, i, k, pre, hold;
   initial forever #25 i_core_clk = ~i_core_clk;
   reset_pin_sequencer #(.DRIVE_CYCLES(D), .SEQ_CYCLES(S)) dut_u (
      .i_core_clk(i_core_clk), .i_srst(i_srst), .i_rst_src(i_rst_src),
      .i_rst_pin(pin), .o_rst_pin(drv), .o_rst_pin_oe(oe), .o_rst_pin_pu(pu),
      .o_int_rst(int_rst), .o_ext_hold(xhold));
   ext_rst_board board_u (.i_oe(oe), .i_drv(drv), .i_ext_low(ext_low), .o_pin(pin));
   // ==========
   // checking and closing
   task close_out;
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s exp %0d got %0d", name, exp, got);
      end
   endtask
   // ==========
   // one sequence: started by source pulse (pre 0), by board low for pre cycles, or by the pending reset (pre -1)
   task run(input int pre, input int hold);
      int j;
      n_oe = 0;
      n_int = 0;
      xh = 1'h0;
      for (j = 0; j < S + hold + 20; j++) begin
         @(negedge i_core_clk);
         // a pending reset is let go at the first step of the run
         if (j == 0) i_srst <= 1'h0;
         if (oe === 1'h1) n_oe++;
         if (int_rst === 1'h1) n_int++;
         if (xhold === 1'h1) xh = 1'h1;
         // stray source pulses inside a running sequence must be ignored
         i_rst_src <= (j == 0 && pre == 0) || (n_int > 0 && n_int < S - 2 && $random(seed) % 2 != 0);
         ext_low <= (j < pre) || (hold > 0 && n_int > 0 && n_int < S + hold);
      end
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (5) @(negedge i_core_clk);
      i_srst <= 1'h0;
      chk("rst_int", 1, int_rst);
      for (i = 0; i < 100 && int_rst !== 1'h0; i++) @(negedge i_core_clk);
      chk("rst_done", 0, int_rst);
      chk("pad", 2'h2, {pu, drv});
      for (k = 0; k < 8; k++) begin
         pre = (k == 2) ? 3 : 0;
         hold = (k < 3 || k == 7) ? 0 : 1 + ($random(seed) & 15);
         // last pass: a reset in mid-drive must restart the whole sequence
         if (k == 7) begin
            pre = -1;
            @(negedge i_core_clk);
            i_rst_src <= 1'h1;
            repeat (5) @(negedge i_core_clk);
            i_srst <= 1'h1;
            repeat (3) @(negedge i_core_clk);
         end
         run(pre, hold);
         chk("oe_len", D, n_oe);
         chk("hold_flag", hold > 0, xh);
         if (hold == 0) chk("int_len", S, n_int);
         else chk("int_ext", 1, n_int >= S + hold && n_int <= S + hold + 4);
      end
      close_out;
   end
   // a hang ends the run as a failure
   initial begin
      #150000;
      bad_count++;
      close_out;
   end
endmodule
